// ### hw/adc_reset_defs.svh
/*
  Timing counts, reset values and limits for the converter reset and
  start-up sequencer. Assumes it is included by bare name.
*/
`ifndef ADC_RESET_DEFS_SVH
`define ADC_RESET_DEFS_SVH

// oscillator cycles counted before power-on reset releases
`define POR_OSC_CYCLES 11'd2006
// oscillator cycles a converter reset takes before the valid flag rises
`define CONV_RST_OSC_CYCLES 11'd16
// gain is unsigned 2.22 fixed point: 1.0 at reset, floor at 0.6
`define GAIN_RESET 24'h400000
`define GAIN_MIN 24'h266666
// filter setting at reset, and oscillator cycles per word at setting 0
`define FILTER_RESET 3'h0
`define WORD_BASE_DIV 16'h8000

`endif

// ### hw/adc_reset_pkg.sv
/*
  Types for the converter reset and start-up sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package adc_reset_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        ST_WAIT_OSC,
        ST_POR_COUNT,
        ST_CMD,
        ST_CONV_RST,
        ST_RESET_HOLD
    } seq_state_t;
endpackage

`default_nettype wire

// ### hw/adc_reset_init_sequencer.sv
/*
  Power-on and software reset sequencer of a serial-port delta-sigma
  converter: oscillator start-up hold, converter reset bit handling,
  reset-valid flag, command state entry, gain register and filter
  word-rate timing. Assumes the serial port decoder on mclk delivers
  one-cycle write, read and command strobes, and that the master clock
  pin is asynchronous and slower than mclk by a wide margin.
*/
`include "adc_reset_defs.svh"
`default_nettype none

//Contract
// - hold reset until oscillator runs, then count 2006 oscillator cycles.
// - during power-on time-out reset serial port and set reset-valid flag.
// - writing converter-reset bit 1 resets converter; completion sets reset-valid flag.
// - while converter-reset bit is 1 other bits stay default; no normal operation.
// - converter-reset bit back to 0 enters command state awaiting a command.
// - gain register settable from 0.6 to just below 4.
// - gain is binary fixed point; one left shift doubles it.
// - eight filter settings; word rate scales with master clock.
module adc_reset_init_sequencer
    import adc_reset_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic master_clock_input,
    input wire logic cfg_wr,
    input wire logic cfg_wr_reset_bit,
    input wire logic cfg_rd,
    input wire logic gain_wr,
    input wire logic [23:0] gain_wdata,
    input wire logic filter_wr,
    input wire logic [2:0] filter_wdata,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    output logic chip_reset,
    output logic port_reset,
    output logic converter_reset_bit,
    output logic reset_valid_flag,
    output logic command_state,
    output logic normal_op,
    output logic [23:0] gain_value,
    output logic [2:0] filter_sel,
    output logic output_word_rate,
    output logic cmd_accept,
    output logic [7:0] cmd_byte_out
);

    // ======================================================================
    // master clock pin sampling
    // ======================================================================
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic osc_lvl_q;
    logic osc_rise;

    // three stages; level moves only once stages two and three agree
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
            osc_lvl_q <= 1'b0;
        end else begin
            osc_s1_q <= master_clock_input;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            if (osc_s2_q == osc_s3_q) begin
                osc_lvl_q <= osc_s3_q;
            end
        end
    end

    // one pulse per oscillator period
    assign osc_rise = (osc_s2_q == osc_s3_q) && osc_s3_q && !osc_lvl_q;

    // ======================================================================
    // sequencer
    // ======================================================================
    seq_state_t state_q;
    logic [10:0] osc_cnt_q;
    logic reset_bit_q;
    logic flag_set;

    // first oscillator edge proves it runs; then count the time-out
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_WAIT_OSC;
            osc_cnt_q <= 11'h000;
            reset_bit_q <= 1'b0;
        end else begin
            case (state_q)
                ST_WAIT_OSC: begin
                    osc_cnt_q <= 11'h000;
                    if (osc_rise) begin
                        state_q <= ST_POR_COUNT;
                    end
                end
                ST_POR_COUNT: begin
                    if (osc_rise) begin
                        if (osc_cnt_q == `POR_OSC_CYCLES - 11'd1) begin
                            state_q <= ST_CMD;
                            osc_cnt_q <= 11'h000;
                        end else begin
                            osc_cnt_q <= osc_cnt_q + 11'd1;
                        end
                    end
                end
                ST_CMD: begin
                    osc_cnt_q <= 11'h000;
                    if (cfg_wr && cfg_wr_reset_bit) begin
                        reset_bit_q <= 1'b1;
                        state_q <= ST_CONV_RST;
                    end
                end
                ST_CONV_RST: begin
                    // writes are ignored until the reset has run its course
                    if (osc_rise) begin
                        if (osc_cnt_q == `CONV_RST_OSC_CYCLES - 11'd1) begin
                            state_q <= ST_RESET_HOLD;
                            osc_cnt_q <= 11'h000;
                        end else begin
                            osc_cnt_q <= osc_cnt_q + 11'd1;
                        end
                    end
                end
                ST_RESET_HOLD: begin
                    if (cfg_wr && !cfg_wr_reset_bit) begin
                        reset_bit_q <= 1'b0;
                        state_q <= ST_CMD;
                    end
                end
                default: begin
                    state_q <= ST_WAIT_OSC;
                    osc_cnt_q <= 11'h000;
                    reset_bit_q <= 1'b0;
                end
            endcase
        end
    end

    // flag rises through the whole time-out and at converter reset completion
    assign flag_set = (state_q == ST_WAIT_OSC) || (state_q == ST_POR_COUNT) ||
                    ((state_q == ST_CONV_RST) && osc_rise &&
                     (osc_cnt_q == `CONV_RST_OSC_CYCLES - 11'd1));

    // ======================================================================
    // reset-valid flag and status outputs
    // ======================================================================
    // a read clears the flag, but a set in the same cycle wins
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reset_valid_flag <= 1'b0;
        end else if (flag_set) begin
            reset_valid_flag <= 1'b1;
        end else if (cfg_rd) begin
            reset_valid_flag <= 1'b0;
        end
    end

    // status levels registered so every output comes from a flip-flop
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            chip_reset <= 1'b1;
            port_reset <= 1'b1;
            converter_reset_bit <= 1'b0;
            command_state <= 1'b0;
            normal_op <= 1'b0;
        end else begin
            chip_reset <= (state_q == ST_WAIT_OSC) || (state_q == ST_POR_COUNT);
            port_reset <= (state_q == ST_WAIT_OSC) || (state_q == ST_POR_COUNT);
            converter_reset_bit <= reset_bit_q;
            command_state <= (state_q == ST_CMD);
            normal_op <= (state_q == ST_CMD) && !reset_bit_q;
        end
    end

    // ======================================================================
    // command byte acceptance
    // ======================================================================
    // bytes outside the command state are dropped, not queued
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_accept <= 1'b0;
            cmd_byte_out <= 8'h00;
        end else begin
            cmd_accept <= cmd_valid && (state_q == ST_CMD);
            if (cmd_valid && (state_q == ST_CMD)) begin
                cmd_byte_out <= cmd_byte;
            end
        end
    end

    // ======================================================================
    // gain and filter registers
    // ======================================================================
    // held at default outside the command state; low writes clamp at 0.6
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            gain_value <= `GAIN_RESET;
            filter_sel <= `FILTER_RESET;
        end else if (state_q != ST_CMD) begin
            gain_value <= `GAIN_RESET;
            filter_sel <= `FILTER_RESET;
        end else begin
            if (gain_wr) begin
                // 2.22 format: top value is 4 minus one lsb, shift left doubles
                gain_value <= (gain_wdata < `GAIN_MIN) ? `GAIN_MIN : gain_wdata;
            end
            if (filter_wr) begin
                filter_sel <= filter_wdata;
            end
        end
    end

    // ======================================================================
    // output word rate timing
    // ======================================================================
    logic [15:0] word_cnt_q;
    logic [15:0] word_div;

    // counted in oscillator cycles, so the rate tracks the master clock
    assign word_div = `WORD_BASE_DIV >> filter_sel;

    // runs only in normal operation; restarts whenever that ends
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            word_cnt_q <= 16'h0000;
            output_word_rate <= 1'b0;
        end else begin
            output_word_rate <= 1'b0;
            if (!normal_op) begin
                word_cnt_q <= 16'h0000;
            end else if (osc_rise) begin
                if (word_cnt_q >= word_div - 16'd1) begin
                    word_cnt_q <= 16'h0000;
                    output_word_rate <= 1'b1;
                end else begin
                    word_cnt_q <= word_cnt_q + 16'd1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### dv/seq_checker.sv
/* seq_checker: concurrent checks on the reset sequencer ports.
   assumes adc_reset_defs.svh is on the include path. */
`include "adc_reset_defs.svh"
`default_nettype none
module seq_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cfg_wr,
    input wire logic cfg_wr_reset_bit,
    input wire logic cfg_rd,
    input wire logic chip_reset,
    input wire logic port_reset,
    input wire logic converter_reset_bit,
    input wire logic reset_valid_flag,
    input wire logic command_state,
    input wire logic normal_op,
    input wire logic [23:0] gain_value,
    input wire logic [2:0] filter_sel,
    input wire logic output_word_rate
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // port checks
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    por_port_a: assert property (port_reset == chip_reset)
        else $error("serial port reset differs from chip reset");
    por_cmd_a: assert property (chip_reset |-> !command_state && !normal_op)
        else $error("command state while held in reset");
    por_flag_a: assert property ($fell(chip_reset) |-> reset_valid_flag)
        else $error("power-on release without valid flag");
    reset_start_a: assert property (command_state && !converter_reset_bit && cfg_wr && cfg_wr_reset_bit
        |-> ##2 converter_reset_bit && !command_state) else $error("converter reset not started");
    flag_src_a: assert property ($rose(reset_valid_flag) |-> chip_reset || converter_reset_bit)
        else $error("valid flag rose outside a reset");
    reset_hold_a: assert property (converter_reset_bit |-> gain_value == `GAIN_RESET &&
        filter_sel == `FILTER_RESET && !normal_op) else $error("registers not default in reset");
    flag_clr_a: assert property (cfg_rd && command_state && !converter_reset_bit |=> !reset_valid_flag)
        else $error("read did not clear valid flag");
    cmd_entry_a: assert property ($fell(converter_reset_bit) |-> command_state && normal_op)
        else $error("release did not enter command state");
    word_gate_a: assert property (output_word_rate |-> normal_op ##1 !output_word_rate)
        else $error("word pulse outside normal operation");
    // main scenarios reached
    cover property ($rose(reset_valid_flag) && converter_reset_bit);
    cover property ($fell(converter_reset_bit));
    cover property (output_word_rate);
endmodule
bind adc_reset_init_sequencer seq_checker chk (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cfg_wr(cfg_wr),
    .cfg_wr_reset_bit(cfg_wr_reset_bit),
    .cfg_rd(cfg_rd),
    .chip_reset(chip_reset),
    .port_reset(port_reset),
    .converter_reset_bit(converter_reset_bit),
    .reset_valid_flag(reset_valid_flag),
    .command_state(command_state),
    .normal_op(normal_op),
    .gain_value(gain_value),
    .filter_sel(filter_sel),
    .output_word_rate(output_word_rate)
);
`default_nettype wire

// ### dv/host_model.sv
/* host_model: host side of the converter reset recovery.
   assumes strobes are taken on the rising edge of mclk. */
`default_nettype none
module host_model #(parameter int GAP = 3) (
    input wire logic mclk,
    input wire logic go,
    input wire logic reset_valid_flag,
    output logic cfg_wr,
    output logic cfg_wr_reset_bit,
    output logic cfg_rd,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic seen = 1'b0;
    // ==========
    // access tasks
    task automatic wr(input logic b);
        @(posedge mclk) #1;
        cfg_wr = 1'b1;
        cfg_wr_reset_bit = b;
        @(posedge mclk) #1;
        cfg_wr = 1'b0;
    endtask
    // slow polling on purpose; the flag seen at the taking edge is the read value
    task automatic rd;
        repeat (GAP) @(posedge mclk);
        #1 cfg_rd = 1'b1;
        @(posedge mclk);
        seen = reset_valid_flag;
        #1 cfg_rd = 1'b0;
    endtask
    initial begin
        cfg_wr = 1'b0;
        cfg_wr_reset_bit = 1'b0;
        cfg_rd = 1'b0;
        done = 1'b0;
        wait (go);
        rd;
        wr(1'b1);
        seen = 1'b0;
        for (int i = 0; i < 200 && !seen; i++) rd;
        wr(1'b0);
        done = 1'b1;
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
/* tb: self-checking bench for the reset sequencer.
   assumes the host model and checker are compiled first. */
`include "adc_reset_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, sys_rst = 1, osc = 0, osc_en = 0, go = 0;
    logic gain_wr = 0, filter_wr = 0, cmd_valid = 0;
    logic [23:0] gain_wdata = 0;
    logic [2:0] filter_wdata = 0;
    logic [7:0] cmd_byte = 0;
    logic cfg_wr, cfg_wr_reset_bit, cfg_rd, done, chip_reset, port_reset, converter_reset_bit;
    logic reset_valid_flag, command_state, normal_op, output_word_rate, cmd_accept;
    logic [23:0] gain_value;
    logic [2:0] filter_sel;
    logic [7:0] cmd_byte_out;
    int failures = 0, n_compared = 0, cyc = 0, c;
    adc_reset_init_sequencer uut (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .master_clock_input(osc),
        .cfg_wr(cfg_wr),
        .cfg_wr_reset_bit(cfg_wr_reset_bit),
        .cfg_rd(cfg_rd),
        .gain_wr(gain_wr),
        .gain_wdata(gain_wdata),
        .filter_wr(filter_wr),
        .filter_wdata(filter_wdata),
        .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte),
        .chip_reset(chip_reset),
        .port_reset(port_reset),
        .converter_reset_bit(converter_reset_bit),
        .reset_valid_flag(reset_valid_flag),
        .command_state(command_state),
        .normal_op(normal_op),
        .gain_value(gain_value),
        .filter_sel(filter_sel),
        .output_word_rate(output_word_rate),
        .cmd_accept(cmd_accept),
        .cmd_byte_out(cmd_byte_out)
    );
    host_model host (
        .mclk(mclk),
        .go(go),
        .reset_valid_flag(reset_valid_flag),
        .cfg_wr(cfg_wr),
        .cfg_wr_reset_bit(cfg_wr_reset_bit),
        .cfg_rd(cfg_rd),
        .done(done)
    );
    always #20 mclk = ~mclk;
    // oscillator pin parked low until started; 320 ns period
    always #160 if (osc_en) osc = ~osc;
    // hang guard; the whole run needs about 45k cycles
    always @(posedge mclk) if (++cyc == 80000) begin
        failures++;
        finish_test;
    end
    // ==========
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic step;
        @(posedge mclk) #1;
    endtask
    task automatic gw(input logic [23:0] d, input logic [23:0] e);
        step;
        gain_wr = 1;
        gain_wdata = d;
        step;
        gain_wr = 0;
        chk(gain_value, e);
    endtask
    task automatic fw(input logic [2:0] n);
        step;
        filter_wr = 1;
        filter_wdata = n;
        step;
        filter_wr = 0;
        chk(filter_sel, n);
    endtask
    task automatic cw(input logic [7:0] b, input logic acc);
        step;
        cmd_valid = 1;
        cmd_byte = b;
        step;
        cmd_valid = 0;
        chk(cmd_accept, acc);
        if (acc) chk(cmd_byte_out, b);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        chk({chip_reset, port_reset, reset_valid_flag, filter_sel}, 6'h30);
        chk(gain_value, `GAIN_RESET);
        #1 sys_rst = 0;
        osc_en = 1;
        for (c = 0; c < 20000 && command_state !== 1'b1; c++) step;
        chk(c >= 16049 && c <= 16058, 1);
        chk({chip_reset, port_reset, reset_valid_flag}, 3'h1);
        $display("test power_on done");
        cw(8'ha5, 1);
        cw(8'h3c, 1);
        gw(`GAIN_RESET << 1, 24'h800000);
        gw(24'h100000, `GAIN_MIN);
        gw(24'hffffff, 24'hffffff);
        fw(3'h5);
        $display("test command_gain done");
        go = 1;
        for (c = 0; c < 300 && converter_reset_bit !== 1'b1; c++) step;
        chk({gain_value, filter_sel, normal_op}, {`GAIN_RESET, `FILTER_RESET, 1'b0});
        cw(8'h11, 0);
        for (c = 0; c < 3000 && done !== 1'b1; c++) step;
        step;
        step;
        chk({converter_reset_bit, command_state, normal_op}, 3'h3);
        cw(8'h22, 1);
        $display("test converter_reset done");
        for (int n = 7; n >= 5; n--) begin
            fw(n[2:0]);
            for (c = 0; c < 70000 && output_word_rate !== 1'b1; c++) step;
            c = 0;
            do begin
                step;
                c++;
            end while (output_word_rate !== 1'b1 && c < 70000);
            chk(c, (`WORD_BASE_DIV >> n) * 8);
        end
        $display("test word_rate done");
        finish_test;
    end
endmodule
`default_nettype wire
